/* File: usec_pkg.sv */
/*
  package for the usb engine control block: register offsets, field positions,
  reset values, timing counts and the event carrier struct.
  assumes a 10 MHz clock and an 8-bit register port.
*/
package usec_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_USB_CONTROL = 8'h20;
  localparam logic [7:0] OFS_DEVICE_ADDRESS = 8'h21;
  localparam logic [7:0] OFS_STALL = 8'h22;
  localparam logic [7:0] OFS_TOKEN_STATUS = 8'h23;
  localparam logic [7:0] OFS_FIFO_CONTROL = 8'h24;
  localparam logic [7:0] OFS_LINE_NOISE = 8'h25;
  localparam logic [7:0] OFS_DIR_TOGGLE = 8'h27;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  // usb control register
  localparam int CTL_SUSPEND = 0;
  localparam int CTL_WAKEUP = 1;
  localparam int CTL_RESUME = 3;
  localparam int CTL_PKT_ERR = 6;
  // token status register
  localparam int TS_AUTO_ADDR = 0;
  localparam int TS_FIFO_ERR = 1;
  localparam int TS_OUT = 2;
  localparam int TS_IN = 3;
  localparam int TS_NAK = 4;
  localparam int TS_PKT_ERR = 5;
  localparam int TS_TOKEN_N = 6;
  localparam int TS_NAK_MASK = 7;
  // fifo access control register
  localparam int FC_REQUEST = 0;
  localparam int FC_TX = 1;
  localparam int FC_CLEAR = 2;
  localparam int FC_ISO_IN_EN = 3;
  localparam int FC_ISO_OUT_EN = 4;
  localparam int FC_SETUP_CMD = 5;
  localparam int FC_READY = 6;
  localparam int FC_ZERO_LEN = 7;
  // line noise register
  localparam int LN_SE0 = 0;
  localparam int LN_SE1 = 1;
  localparam int LN_DMINUS = 2;
  localparam int LN_DPLUS = 3;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_USB_CONTROL = 8'h80;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 10_000_000;
  localparam int IDLE_SUSPEND_US = 3000;
  localparam int IDLE_SUSPEND_CYC = IDLE_SUSPEND_US * (CLK_HZ / 1_000_000);

  localparam int NUM_EP = 5;

  // events from the serial engine, one-cycle pulses except levels noted
  typedef struct packed {
    logic setup_token;
    logic bus_reset;
    logic in_done;
    logic out_data;
    logic out_zero;
    logic nak_sent;
    logic pkt_error;
    logic fifo_error;
    logic se0_noise;
    logic se1_noise;
    logic resume;
    logic bus_activity;
    logic fifo_fill;
    logic [NUM_EP-1:0] ep_stall;
  } usec_evt_s;

  // live levels from the engine
  typedef struct packed {
    logic in_token;
    logic token_active;
    logic fifo_ready;
    logic dminus;
    logic dplus;
  } usec_lvl_s;

endpackage : usec_pkg

/* File: usec_ctrl.sv */
/*
  serial interface engine control and status registers of a full-speed usb
  function. assumes the engine core delivers events and levels on the usec
  structs, synchronous to clk, and firmware uses the simple register port.
*/
`timescale 1ns/1ps

module usec_ctrl #(
  parameter int IDLE_CYC = usec_pkg::IDLE_SUSPEND_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire usec_pkg::usec_evt_s evt,
  input wire usec_pkg::usec_lvl_s lvl,
  input wire logic fifo_rd,
  output logic [6:0] dev_addr,
  output logic fifo_request,
  output logic fifo_xfer_end,
  output logic fifo_clear,
  output logic force_tx_err,
  output logic iso_in_int_en,
  output logic iso_out_int_en,
  output logic [4:0] ep_dir,
  output logic data_toggle,
  output logic wakeup_signal,
  output logic usb_int
);
  import usec_pkg::*;

  // ----------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
    return w && (a == ofs);
  endfunction

  logic wr_ctl, wr_adr, wr_stall, wr_ts, wr_fc, wr_ln, wr_dt;
  assign wr_ctl = wr_hit(reg_addr, OFS_USB_CONTROL, reg_wr);
  assign wr_adr = wr_hit(reg_addr, OFS_DEVICE_ADDRESS, reg_wr);
  assign wr_stall = wr_hit(reg_addr, OFS_STALL, reg_wr);
  assign wr_ts = wr_hit(reg_addr, OFS_TOKEN_STATUS, reg_wr);
  assign wr_fc = wr_hit(reg_addr, OFS_FIFO_CONTROL, reg_wr);
  assign wr_ln = wr_hit(reg_addr, OFS_LINE_NOISE, reg_wr);
  assign wr_dt = wr_hit(reg_addr, OFS_DIR_TOGGLE, reg_wr);

  logic [7:0] device_address_register;
  logic [7:0] endpoint_stall_flags;
  logic [7:0] endpoint_direction_toggle;
  logic [7:0] usb_control_register;
  logic auto_address_update, fifo_err, out_flag, packet_error_flag, nak_mask;
  logic request, tx, clear, iso_in, iso_out, setup_command_flag, zero_length_flag;
  logic se0, se1, suspend, resume_flag, addr_pending, tx_q, req_q, under_run;

  // ----------------------------------------------------------------
  // device address
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      device_address_register <= RST_ZERO;
    end else if (wr_adr) begin
      device_address_register <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dev_addr <= 7'h00;
      addr_pending <= 1'b0;
    end else if (evt.bus_reset) begin
      dev_addr <= 7'h00;
      addr_pending <= 1'b0;
    end else if (wr_adr && !auto_address_update) begin
      dev_addr <= reg_wdata[6:0];
      addr_pending <= 1'b0;
    end else if (wr_adr) begin
      addr_pending <= 1'b1;
    end else if (evt.in_done && (addr_pending || auto_address_update)) begin
      dev_addr <= device_address_register[6:0];
      addr_pending <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // stall flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      endpoint_stall_flags <= RST_ZERO;
    end else if (evt.bus_reset || evt.setup_token) begin
      endpoint_stall_flags <= RST_ZERO;
    end else begin
      endpoint_stall_flags <= (wr_stall ? reg_wdata : endpoint_stall_flags)
        | {3'b000, evt.ep_stall};
    end
  end

  // ----------------------------------------------------------------
  // token status; hardware set wins over firmware clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_address_update <= 1'b0;
      nak_mask <= 1'b0;
    end else if (wr_ts) begin
      auto_address_update <= reg_wdata[TS_AUTO_ADDR];
      nak_mask <= reg_wdata[TS_NAK_MASK];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fifo_err <= 1'b0;
      packet_error_flag <= 1'b0;
    end else begin
      fifo_err <= evt.fifo_error | (wr_ts ? reg_wdata[TS_FIFO_ERR] : fifo_err);
      packet_error_flag <= evt.pkt_error
        | (wr_ts ? reg_wdata[TS_PKT_ERR] : (wr_ctl ? reg_wdata[CTL_PKT_ERR] : packet_error_flag));
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_flag <= 1'b0;
    end else if (evt.out_data) begin
      out_flag <= 1'b1;
    end else if (evt.setup_token || fifo_rd) begin
      out_flag <= 1'b0;
    end else if (wr_ts) begin
      out_flag <= reg_wdata[TS_OUT];
    end
  end

  // ----------------------------------------------------------------
  // fifo access control
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      request <= 1'b0;
      tx <= 1'b0;
      clear <= 1'b0;
      iso_in <= 1'b0;
      iso_out <= 1'b0;
    end else if (evt.bus_reset) begin
      request <= 1'b0;
      tx <= 1'b0;
      clear <= 1'b0;
      iso_in <= 1'b0;
      iso_out <= 1'b0;
    end else if (wr_fc) begin
      request <= reg_wdata[FC_REQUEST];
      tx <= reg_wdata[FC_TX];
      clear <= reg_wdata[FC_CLEAR];
      iso_in <= reg_wdata[FC_ISO_IN_EN];
      iso_out <= reg_wdata[FC_ISO_OUT_EN];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_command_flag <= 1'b0;
    end else if (evt.bus_reset) begin
      setup_command_flag <= 1'b0;
    end else if (evt.fifo_fill) begin
      setup_command_flag <= evt.setup_token;
    end else if (wr_fc) begin
      setup_command_flag <= reg_wdata[FC_SETUP_CMD];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      zero_length_flag <= 1'b0;
    end else if (evt.bus_reset) begin
      zero_length_flag <= 1'b0;
    end else if (evt.out_zero) begin
      zero_length_flag <= 1'b1;
    end else if (fifo_rd) begin
      zero_length_flag <= 1'b0;
    end
  end

  // transfer end: tx falls on a write, rises on a read; tx set with request opens
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_q <= 1'b0;
      req_q <= 1'b0;
    end else begin
      tx_q <= tx;
      req_q <= request;
    end
  end
  assign fifo_xfer_end = request && req_q && (tx != tx_q);

  // under-run held from clear until next fill
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      under_run <= 1'b0;
    end else if (evt.bus_reset || evt.fifo_fill) begin
      under_run <= 1'b0;
    end else if (clear) begin
      under_run <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // direction and toggle, line noise
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      endpoint_direction_toggle <= RST_ZERO;
    end else if (wr_dt) begin
      endpoint_direction_toggle <= reg_wdata;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      se0 <= 1'b0;
      se1 <= 1'b0;
    end else begin
      se0 <= evt.se0_noise | (wr_ln ? reg_wdata[LN_SE0] : se0);
      se1 <= evt.se1_noise | (wr_ln ? reg_wdata[LN_SE1] : se1);
    end
  end

  // ----------------------------------------------------------------
  // suspend, resume, remote wake-up
  // ----------------------------------------------------------------
  logic [$clog2(IDLE_CYC+1)-1:0] idle_cnt;
  logic idle_hit, wakeup_bit;
  assign idle_hit = (idle_cnt == ($bits(idle_cnt))'(IDLE_CYC));

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      idle_cnt <= '0;
    end else if (evt.bus_activity || evt.bus_reset) begin
      idle_cnt <= '0;
    end else if (!idle_hit) begin
      idle_cnt <= idle_cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend <= 1'b0;
      resume_flag <= 1'b0;
    end else if (evt.resume && suspend) begin
      resume_flag <= 1'b1;
    end else if (evt.bus_activity || evt.bus_reset) begin
      suspend <= 1'b0;
      resume_flag <= 1'b0;
    end else if (idle_hit) begin
      suspend <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wakeup_bit <= 1'b0;
      wakeup_signal <= 1'b0;
    end else begin
      if (wr_ctl) begin
        wakeup_bit <= reg_wdata[CTL_WAKEUP];
      end
      wakeup_signal <= wakeup_bit && suspend;
    end
  end

  // ----------------------------------------------------------------
  // interrupt and outputs
  // ----------------------------------------------------------------
  logic suspend_q, resume_q;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      suspend_q <= 1'b0;
      resume_q <= 1'b0;
      usb_int <= 1'b0;
    end else begin
      suspend_q <= suspend;
      resume_q <= resume_flag;
      usb_int <= (suspend && !suspend_q) || (resume_flag && !resume_q)
        || (evt.nak_sent && !nak_mask);
    end
  end

  assign fifo_request = request;
  assign fifo_clear = clear;
  assign force_tx_err = under_run;
  assign iso_in_int_en = iso_in;
  assign iso_out_int_en = iso_out;
  assign ep_dir = endpoint_direction_toggle[4:0];
  assign data_toggle = endpoint_direction_toggle[7];

  always_comb begin
    usb_control_register = RST_USB_CONTROL;
    usb_control_register[CTL_SUSPEND] = suspend;
    usb_control_register[CTL_WAKEUP] = wakeup_bit;
    usb_control_register[CTL_RESUME] = resume_flag;
    usb_control_register[CTL_PKT_ERR] = packet_error_flag;
  end

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= RST_ZERO;
    end else if (!reg_rd) begin
      reg_rdata <= RST_ZERO;
    end else if (reg_addr == OFS_USB_CONTROL) begin
      reg_rdata <= usb_control_register;
    end else if (reg_addr == OFS_DEVICE_ADDRESS) begin
      reg_rdata <= device_address_register;
    end else if (reg_addr == OFS_STALL) begin
      reg_rdata <= endpoint_stall_flags;
    end else if (reg_addr == OFS_TOKEN_STATUS) begin
      reg_rdata <= {nak_mask, !lvl.token_active, packet_error_flag, evt.nak_sent,
                    lvl.in_token, out_flag, fifo_err, auto_address_update};
    end else if (reg_addr == OFS_FIFO_CONTROL) begin
      reg_rdata <= {zero_length_flag, lvl.fifo_ready, setup_command_flag, iso_out,
                    iso_in, clear, tx, request};
    end else if (reg_addr == OFS_LINE_NOISE) begin
      reg_rdata <= {4'h0, lvl.dplus, lvl.dminus, se1, se0};
    end else if (reg_addr == OFS_DIR_TOGGLE) begin
      reg_rdata <= endpoint_direction_toggle;
    end else begin
      reg_rdata <= RST_ZERO;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_idle_run;
    !evt.bus_activity && !evt.bus_reset;
  endsequence

  a_stall_clear: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.bus_reset || evt.setup_token) |=> endpoint_stall_flags == 8'h00)
    else $error("stall flags not cleared");
  a_addr_immediate: assert property (@(posedge clk) disable iff (!rst_n)
    (wr_adr && !auto_address_update && !evt.bus_reset) |=> dev_addr == $past(reg_wdata[6:0]))
    else $error("address not adopted at once");
  a_fifo_err_sticky: assert property (@(posedge clk) disable iff (!rst_n)
    evt.fifo_error |=> fifo_err)
    else $error("fifo error flag not set");
  a_out_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    evt.out_data |=> out_flag)
    else $error("out flag not set");
  a_pkt_err_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (packet_error_flag && !wr_ts && !wr_ctl) |=> packet_error_flag)
    else $error("packet error flag dropped");
  a_nak_int: assert property (@(posedge clk) disable iff (!rst_n)
    (evt.nak_sent && !nak_mask) |=> usb_int)
    else $error("nak did not interrupt");
  a_fc_reset: assert property (@(posedge clk) disable iff (!rst_n)
    evt.bus_reset |=> !request && !tx && !clear && !iso_in && !iso_out && !zero_length_flag)
    else $error("fifo control not cleared");
  a_zero_len: assert property (@(posedge clk) disable iff (!rst_n)
    (fifo_rd && !evt.out_zero) |=> !zero_length_flag)
    else $error("zero length flag not cleared by read");
  a_suspend_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (idle_hit && !suspend) ##0 s_idle_run ##0 !evt.resume |=> suspend ##1 usb_int)
    else $error("suspend not entered");
  a_resume_clear: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(suspend) |-> !resume_flag)
    else $error("resume not cleared with suspend");

endmodule // usec_ctrl

/* File: usec_host_model.sv */
/*
  usec_host_model: far side of the engine control block, the bus host as
  seen through the serial engine's event and level strobes.
  assumes the bench pulses ev_req for one clock and drives lv_req as levels.
*/
`timescale 1ns/1ps
module usec_host_model #(
  parameter int WAKE_DLY = 6
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire usec_pkg::usec_evt_s ev_req,
  input wire usec_pkg::usec_lvl_s lv_req,
  input wire logic idle,
  input wire logic wakeup_signal,
  output usec_pkg::usec_evt_s evt,
  output usec_pkg::usec_lvl_s lvl
);
  import usec_pkg::*;

  logic [1:0] act_cnt;
  logic [3:0] wake_cnt;

  // ----------------------------------------------------------------
  // frame traffic, stands still while idle
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_cnt <= 2'h0;
    end else begin
      act_cnt <= act_cnt + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // host answers a wake-up with resume
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_cnt <= 4'h0;
    end else if (wakeup_signal && wake_cnt == 4'h0) begin
      wake_cnt <= 4'(WAKE_DLY);
    end else if (wake_cnt != 4'h0) begin
      wake_cnt <= wake_cnt - 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      evt <= '0;
      lvl <= '0;
    end else begin
      evt <= ev_req;
      evt.bus_activity <= ev_req.bus_activity | (!idle && act_cnt == 2'h0);
      evt.resume <= ev_req.resume | (wake_cnt == 4'h1);
      lvl <= lv_req;
    end
  end
endmodule // usec_host_model

/* File: test_usec_ctrl.sv */
/*
  test_usec_ctrl: self-checking bench for the usb engine control block.
  assumes usec_pkg, usec_ctrl and usec_host_model are compiled before it.
*/
`timescale 1ns/1ps
module test_usec_ctrl;
  import usec_pkg::*;

  logic clk;
  logic rst_n;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  usec_evt_s ev_req;
  usec_evt_s evt;
  usec_lvl_s lv_req;
  usec_lvl_s lvl;
  logic fifo_rd;
  logic idle;
  logic [6:0] dev_addr;
  logic fifo_request;
  logic fifo_xfer_end;
  logic fifo_clear;
  logic force_tx_err;
  logic iso_in_int_en;
  logic iso_out_int_en;
  logic [4:0] ep_dir;
  logic data_toggle;
  logic wakeup_signal;
  logic usb_int;
  logic [7:0] int_cnt;
  logic [7:0] xend_cnt;
  logic [7:0] n;
  int cycles;
  int num_errors;
  int comparisons;

  usec_ctrl #(.IDLE_CYC(20)) u_usec_ctrl (
    .clk(clk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .evt(evt),
    .lvl(lvl),
    .fifo_rd(fifo_rd),
    .dev_addr(dev_addr),
    .fifo_request(fifo_request),
    .fifo_xfer_end(fifo_xfer_end),
    .fifo_clear(fifo_clear),
    .force_tx_err(force_tx_err),
    .iso_in_int_en(iso_in_int_en),
    .iso_out_int_en(iso_out_int_en),
    .ep_dir(ep_dir),
    .data_toggle(data_toggle),
    .wakeup_signal(wakeup_signal),
    .usb_int(usb_int)
  );

  usec_host_model u_usec_host_model (
    .clk(clk),
    .rst_n(rst_n),
    .ev_req(ev_req),
    .lv_req(lv_req),
    .idle(idle),
    .wakeup_signal(wakeup_signal),
    .evt(evt),
    .lvl(lvl)
  );

  // ----------------------------------------------------------------
  // clock, pulse monitors, hang guard
  // ----------------------------------------------------------------
  always #50 clk = ~clk;

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (usb_int === 1'b1) begin
      int_cnt <= int_cnt + 8'h1;
    end
    if (fifo_xfer_end === 1'b1) begin
      xend_cnt <= xend_cnt + 8'h1;
    end
    if (cycles == 3000) begin
      num_errors++;
      $display("FAIL run time expected under 3000 seen 3000");
      summarize();
    end
  end

  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic rdc(input string name, input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk(name, exp, reg_rdata);
  endtask

  // one-cycle engine event, returns once the flags have taken it
  task automatic ev(input usec_evt_s e);
    @(posedge clk);
    ev_req <= e;
    @(posedge clk);
    ev_req <= '0;
    repeat (2) @(negedge clk);
  endtask

  task automatic frd();
    @(posedge clk);
    fifo_rd <= 1'b1;
    @(posedge clk);
    fifo_rd <= 1'b0;
    @(negedge clk);
  endtask

  task automatic summarize();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ev_req = '0;
    lv_req = '0;
    fifo_rd = 1'b0;
    idle = 1'b0;
    int_cnt = 8'h00;
    xend_cnt = 8'h00;
    cycles = 0;
    num_errors = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rdc("control", OFS_USB_CONTROL, RST_USB_CONTROL);
    rdc("stall", OFS_STALL, RST_ZERO);
    rdc("address", OFS_DEVICE_ADDRESS, RST_ZERO);
    rdc("fifo ctl", OFS_FIFO_CONTROL, RST_ZERO);
    rdc("unmapped", 8'h26, RST_ZERO);
    rdc("token st", OFS_TOKEN_STATUS, 8'h40);
    lv_req <= '{in_token: 1'b1, token_active: 1'b1, dminus: 1'b1, default: '0};
    rdc("token st", OFS_TOKEN_STATUS, 8'h08);
    // stall flags: set, then cleared by setup and by bus reset
    ev('{ep_stall: 5'h05, default: '0});
    rdc("stall", OFS_STALL, 8'h05);
    ev('{setup_token: 1'b1, default: '0});
    rdc("stall", OFS_STALL, RST_ZERO);
    wr(OFS_STALL, 8'h12);
    ev('{bus_reset: 1'b1, default: '0});
    rdc("stall", OFS_STALL, RST_ZERO);
    // address adoption, direct and after an in read
    wr(OFS_DEVICE_ADDRESS, 8'h15);
    chk("dev_addr", 8'h15, {1'b0, dev_addr});
    wr(OFS_TOKEN_STATUS, 8'h01);
    wr(OFS_DEVICE_ADDRESS, 8'h2a);
    chk("dev_addr", 8'h15, {1'b0, dev_addr});
    ev('{in_done: 1'b1, default: '0});
    chk("dev_addr", 8'h2a, {1'b0, dev_addr});
    rdc("address", OFS_DEVICE_ADDRESS, 8'h2a);
    ev('{setup_token: 1'b1, default: '0});
    wr(OFS_TOKEN_STATUS, 8'h00);
    // sticky error flags
    ev('{fifo_error: 1'b1, pkt_error: 1'b1, se0_noise: 1'b1, se1_noise: 1'b1, default: '0});
    rdc("token st", OFS_TOKEN_STATUS, 8'h2a);
    rdc("control", OFS_USB_CONTROL, 8'hc0);
    rdc("noise", OFS_LINE_NOISE, 8'h07);
    wr(OFS_TOKEN_STATUS, 8'h00);
    wr(OFS_LINE_NOISE, 8'h00);
    rdc("token st", OFS_TOKEN_STATUS, 8'h08);
    rdc("noise", OFS_LINE_NOISE, 8'h04);
    // out flag
    ev('{out_data: 1'b1, default: '0});
    rdc("token st", OFS_TOKEN_STATUS, 8'h0c);
    frd();
    rdc("token st", OFS_TOKEN_STATUS, 8'h08);
    ev('{out_data: 1'b1, default: '0});
    ev('{setup_token: 1'b1, default: '0});
    rdc("token st", OFS_TOKEN_STATUS, 8'h08);
    // nak interrupt, unmasked then masked
    n = int_cnt;
    @(posedge clk);
    ev_req <= '{nak_sent: 1'b1, default: '0};
    @(posedge clk);
    ev_req <= '0;
    reg_rd <= 1'b1;
    reg_addr <= OFS_TOKEN_STATUS;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk("token st", 8'h18, reg_rdata);
    repeat (2) @(negedge clk);
    chk("nak int", n + 8'h1, int_cnt);
    wr(OFS_TOKEN_STATUS, 8'h80);
    ev('{nak_sent: 1'b1, default: '0});
    repeat (2) @(negedge clk);
    chk("nak int", n + 8'h1, int_cnt);
    rdc("token st", OFS_TOKEN_STATUS, 8'h88);
    wr(OFS_TOKEN_STATUS, 8'h00);
    // fifo handshake: request after ready, tx edge ends transfer
    lv_req.fifo_ready <= 1'b1;
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'h40);
    wr(OFS_FIFO_CONTROL, 8'h1b);
    chk("fifo out", 8'h07, {5'h0, fifo_request, iso_in_int_en, iso_out_int_en});
    n = xend_cnt;
    wr(OFS_FIFO_CONTROL, 8'h19);
    repeat (2) @(negedge clk);
    chk("xfer end", n + 8'h1, xend_cnt);
    wr(OFS_FIFO_CONTROL, 8'h18);
    wr(OFS_FIFO_CONTROL, 8'h1c);
    @(negedge clk);
    chk("clear", 8'h03, {6'h0, fifo_clear, force_tx_err});
    wr(OFS_FIFO_CONTROL, 8'h18);
    ev('{fifo_fill: 1'b1, default: '0});
    chk("tx err", 8'h00, {7'h0, force_tx_err});
    ev('{setup_token: 1'b1, fifo_fill: 1'b1, default: '0});
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'h78);
    ev('{fifo_fill: 1'b1, default: '0});
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'h58);
    ev('{out_zero: 1'b1, default: '0});
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'hd8);
    frd();
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'h58);
    ev('{bus_reset: 1'b1, default: '0});
    rdc("fifo ctl", OFS_FIFO_CONTROL, 8'h40);
    chk("dev_addr", 8'h00, {1'b0, dev_addr});
    // direction and toggle
    wr(OFS_DIR_TOGGLE, 8'h8a);
    rdc("dir tgl", OFS_DIR_TOGGLE, 8'h8a);
    chk("dir out", 8'h8a, {data_toggle, 2'b00, ep_dir});
    // suspend, remote wake-up, resume
    @(posedge clk);
    idle <= 1'b1;
    n = int_cnt;
    rdc("control", OFS_USB_CONTROL, 8'h80);
    repeat (25) @(negedge clk);
    rdc("control", OFS_USB_CONTROL, 8'h81);
    chk("susp int", n + 8'h1, int_cnt);
    wr(OFS_USB_CONTROL, 8'h02);
    repeat (12) @(negedge clk);
    rdc("control", OFS_USB_CONTROL, 8'h8b);
    chk("resume int", n + 8'h2, int_cnt);
    wr(OFS_USB_CONTROL, 8'h00);
    @(posedge clk);
    idle <= 1'b0;
    repeat (12) @(negedge clk);
    rdc("control", OFS_USB_CONTROL, 8'h80);
    summarize();
  end
endmodule // test_usec_ctrl
